// ---- emw_pkg.sv ----
// Constants and types for the external memory map and wait-state block
// How it works
// RL1 - Dual-access RAM is 16K words as two independent 8K-word blocks.
// RL2 - Each RAM block serves two reads, or a read and a write, per cycle.
// RL3 - RAM decodes at data 0080h-3FFFh, and in program space when overlay set.
// RL4 - On-chip mask ROM holds 4K words of 16 bits.
// RL5 - Boot mode pin low at reset starts execution at ROM address FF80h.
// RL6 - ROM regions: boot loader, law tables, sine table, vectors, reserved rest.
// RL7 - Application code leaves FF00h-FF7Fh unused for factory testing.
// RL8 - Only address bits 5..0 leave the device; 64 locations repeat.
// RL9 - External latch on an I/O write supplies upper address bits A6-A15.
// RL10 - Interrupt or trap loads the program counter with the vector address.
// RL11 - Each vector occupies four consecutive program words.
// RL12 - Vectors start at FF80h; page pointer relocates them to any 128-word page.
// RL13 - Hardware reset sets all page pointer bits to one, reset vector FF80h.
// RL14 - Programmed wait states stretch an external cycle by at most 14.
// RL15 - Devices needing more than 14 waits hold READY low to extend.
// RL16 - All ranges zero waits gates off the wait generator clock.
// RL17 - Low 15 config bits are five 3-bit fields of 0 to 7 waits.
// RL18 - Multiplier select bit scales every base count by 1 or 2.
// RL19 - After reset every external access gets seven wait states.
// RL20 - Boot loader downloads through serial port 8/16-bit or host port.
// RL21 - Fields: 14-12 I/O, 11-9 upper data, 8-6 lower data, 5-0 program.
// RL22 - Multiplier one doubles base counts up to 14; zero leaves them.
// RL23 - Count scaled waits first, then finish only when READY is high.
`default_nettype none
package emw_pkg;
  localparam int          AW            = 16;
  localparam int          DW            = 16;
  localparam int          RAM_BLK_WORDS = 8192;
  localparam int          RAM_IDX_W     = 13;
  localparam int          ROM_WORDS     = 4096;
  localparam int          ROM_IDX_W     = 12;
  localparam int          EXT_AW        = 6;
  localparam int          VECTOR_PAGE_POINTER_W        = 9;
  localparam int          VEC_SLOT_W    = 5;
  localparam int          VEC_WORD_W    = 2;
  localparam int          WCNT_W        = 4;
  // Memory mapped register addresses
  localparam logic [7:0]  WAIT_CFG_ADDR = 8'h28;
  localparam logic [7:0]  WAIT_CTL_ADDR = 8'h2b;
  localparam logic [7:0]  PROCESSOR_MODE_STATUS_ADDR     = 8'h1d;
  // Field positions
  localparam int          F_IO_LSB      = 12;
  localparam int          F_DHI_LSB     = 9;
  localparam int          F_DLO_LSB     = 6;
  localparam int          F_PHI_LSB     = 3;
  localparam int          F_PLO_LSB     = 0;
  localparam int          F_W           = 3;
  localparam int          XPA_BIT       = 15;
  localparam int          OVERLAY_ENABLE_BIT      = 5;
  localparam int          VECTOR_PAGE_POINTER_LSB      = 7;
  // Reset values
  localparam logic [15:0] WAIT_CFG_RST  = 16'h7fff;
  localparam logic [8:0]  VECTOR_PAGE_POINTER_RST      = 9'h1ff;
  // Address map
  localparam logic [15:0] RAM_LO        = 16'h0080;
  localparam logic [15:0] RAM_HI        = 16'h3fff;
  localparam logic [15:0] RAM_BLK1      = 16'h2000;
  localparam logic [15:0] ROM_BASE      = 16'hf000;
  localparam logic [15:0] BOOT_LO       = 16'hf800;
  localparam logic [15:0] BOOT_HI       = 16'hfbff;
  localparam logic [15:0] MU_LO         = 16'hfc00;
  localparam logic [15:0] A_LO          = 16'hfd00;
  localparam logic [15:0] SINE_LO       = 16'hfe00;
  localparam logic [15:0] SINE_HI       = 16'hfeff;
  localparam logic [15:0] TEST_LO       = 16'hff00;
  localparam logic [15:0] VEC_LO        = 16'hff80;
  localparam logic [15:0] DATA_HI_BASE  = 16'h8000;
  localparam logic [15:0] RESET_VECTOR  = 16'hff80;
  typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} emw_space_t;
  typedef enum logic [2:0] {
    RG_NONE, RG_BOOT, RG_MULAW, RG_ALAW, RG_SINE, RG_VECT, RG_RSVD
  } emw_rom_rgn_t;
endpackage : emw_pkg
`default_nettype wire

// ---- emw_top.sv ----
// External memory map decode, on-chip memories, vectors and wait states
`default_nettype none
module emw_top (
  // Clock, reset and boot mode strap
  input  wire  logic                       clk_i,
  input  wire  logic                       rstn_i,
  input  wire  logic                       boot_mode_select_pin_i,
  // Memory mapped register port
  input  wire  logic                       mmr_wr_i,
  input  wire  logic [7:0]                 mmr_addr_i,
  input  wire  logic [emw_pkg::DW-1:0]     mmr_wdata_i,
  output var   logic [emw_pkg::DW-1:0]     mmr_rdata_o,
  // Core access, port A read or write
  input  wire  logic                       acc_req_i,
  input  wire  logic                       acc_we_i,
  input  wire  emw_pkg::emw_space_t        acc_space_i,
  input  wire  logic [emw_pkg::AW-1:0]     acc_addr_i,
  input  wire  logic [emw_pkg::DW-1:0]     acc_wdata_i,
  output var   logic [emw_pkg::DW-1:0]     acc_rdata_o,
  output var   logic                       acc_done_o,
  output var   logic                       acc_busy_o,
  output var   emw_pkg::emw_rom_rgn_t      acc_rom_rgn_o,
  // Core access, port B read only
  input  wire  logic                       rdb_req_i,
  input  wire  logic [emw_pkg::AW-1:0]     rdb_addr_i,
  output var   logic [emw_pkg::DW-1:0]     rdb_data_o,
  // Vector request
  input  wire  logic                       vec_take_i,
  input  wire  logic [emw_pkg::VEC_SLOT_W-1:0] vec_slot_i,
  output var   logic [emw_pkg::AW-1:0]     pc_load_o,
  output var   logic                       pc_load_vld_o,
  // ROM loader
  input  wire  logic                       rom_wr_i,
  input  wire  logic [emw_pkg::ROM_IDX_W-1:0] rom_idx_i,
  input  wire  logic [emw_pkg::DW-1:0]     rom_wdata_i,
  // External bus
  output var   logic [emw_pkg::EXT_AW-1:0] ext_addr_o,
  output var   logic [emw_pkg::DW-1:0]     ext_dout_o,
  output var   logic                       ext_dout_oe_o,
  input  wire  logic [emw_pkg::DW-1:0]     ext_din_i,
  output var   logic                       ext_strobe_o,
  output var   logic                       ext_rw_o,
  output var   emw_pkg::emw_space_t        ext_space_o,
  input  wire  logic                       ready_i,
  output var   logic                       wait_clk_en_o,
  output var   logic                       boot_mode_o
);
  import emw_pkg::*;

  typedef struct packed {
    logic [DW-1:0]      wait_cfg;
    logic               wait_mult;
    logic [VECTOR_PAGE_POINTER_W-1:0]  vector_page_pointer;
    logic               overlay_enable;
    logic               boot_rom;
    logic               rst_seen;
    logic               ext_busy;
    logic [WCNT_W-1:0]  wcnt;
    logic [EXT_AW-1:0]  ext_addr;
    logic [DW-1:0]      ext_dout;
    logic               ext_oe;
    logic               ext_rw;
    emw_space_t         ext_space;
    logic [DW-1:0]      rdata;
    logic               done;
    emw_rom_rgn_t       rgn;
    logic [DW-1:0]      rdb;
    logic [AW-1:0]      pc;
    logic               pc_vld;
    logic [DW-1:0]      mmr_rd;
    logic               wclk_en;
  } emw_state_t;

  emw_state_t st_ff;
  emw_state_t nxt_st;

  // Flip-flop storage for on-chip memories
  logic [DW-1:0] ram0_ff [RAM_BLK_WORDS]; // see RL1
  logic [DW-1:0] ram1_ff [RAM_BLK_WORDS]; // see RL1
  logic [DW-1:0] rom_ff  [ROM_WORDS];     // see RL4

  logic              a_ram;
  logic              a_rom;
  logic              b_ram;
  logic              b_rom;
  logic              a_ext;
  logic [RAM_IDX_W-1:0] a_ridx;
  logic [RAM_IDX_W-1:0] b_ridx;
  logic [F_W-1:0]    base_w;
  logic [WCNT_W-1:0] scaled_w;
  logic [DW-1:0]     a_mem_rd;
  logic [DW-1:0]     b_mem_rd;

  function automatic logic ram_hit(input emw_space_t sp, input logic [AW-1:0] a, input logic ov);
    ram_hit = (a >= RAM_LO) && (a <= RAM_HI) &&
              (sp == SP_DATA || (sp == SP_PROG && ov)); // see RL3
  endfunction

  function automatic logic rom_hit(input emw_space_t sp, input logic [AW-1:0] a, input logic bt);
    rom_hit = (sp == SP_PROG) && bt && (a >= ROM_BASE);
  endfunction

  function automatic emw_rom_rgn_t rom_rgn(input logic [AW-1:0] a);
    if (a >= BOOT_LO && a <= BOOT_HI) begin // see RL6
      rom_rgn = RG_BOOT; // see RL20
    end else if (a >= MU_LO && a < A_LO) begin
      rom_rgn = RG_MULAW;
    end else if (a >= A_LO && a < SINE_LO) begin
      rom_rgn = RG_ALAW;
    end else if (a >= SINE_LO && a <= SINE_HI) begin
      rom_rgn = RG_SINE;
    end else if (a >= VEC_LO) begin
      rom_rgn = RG_VECT;
    end else begin
      rom_rgn = RG_RSVD; // see RL7
    end
  endfunction

  always_comb begin
    a_ram  = ram_hit(acc_space_i, acc_addr_i, st_ff.overlay_enable);
    a_rom  = rom_hit(acc_space_i, acc_addr_i, st_ff.boot_rom);
    b_ram  = ram_hit(SP_DATA, rdb_addr_i, st_ff.overlay_enable);
    b_rom  = rom_hit(SP_PROG, rdb_addr_i, st_ff.boot_rom);
    a_ext  = !a_ram && !a_rom;
    a_ridx = acc_addr_i[RAM_IDX_W-1:0];
    b_ridx = rdb_addr_i[RAM_IDX_W-1:0];
    // Two-port reads: each block has its own read ports
    a_mem_rd = '0;
    b_mem_rd = '0;
    if (a_ram) begin // see RL2
      a_mem_rd = (acc_addr_i >= RAM_BLK1) ? ram1_ff[a_ridx] : ram0_ff[a_ridx];
    end else if (a_rom) begin
      a_mem_rd = rom_ff[acc_addr_i[ROM_IDX_W-1:0]];
    end
    if (b_ram) begin // see RL2
      b_mem_rd = (rdb_addr_i >= RAM_BLK1) ? ram1_ff[b_ridx] : ram0_ff[b_ridx];
    end else if (b_rom) begin
      b_mem_rd = rom_ff[rdb_addr_i[ROM_IDX_W-1:0]];
    end
    // Range select for wait field
    case (acc_space_i) // see RL21
      SP_IO:   base_w = st_ff.wait_cfg[F_IO_LSB +: F_W];
      SP_DATA: base_w = acc_addr_i[AW-1] ? st_ff.wait_cfg[F_DHI_LSB +: F_W] : st_ff.wait_cfg[F_DLO_LSB +: F_W];
      default: begin
        if (st_ff.wait_cfg[XPA_BIT] || !acc_addr_i[AW-1]) begin
          base_w = st_ff.wait_cfg[F_PLO_LSB +: F_W];
        end else begin
          base_w = st_ff.wait_cfg[F_PHI_LSB +: F_W];
        end
      end
    endcase
    // Doubling caps at 14 cycles
    scaled_w = st_ff.wait_mult ? {base_w, 1'b0} : {1'b0, base_w}; // see RL18 RL22 RL14
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.done   = 1'b0;
    nxt_st.pc_vld = 1'b0;
    nxt_st.rdb    = b_mem_rd;
    nxt_st.rst_seen = 1'b1;
    // Boot strap caught on the first edge after reset release
    if (!st_ff.rst_seen) begin
      nxt_st.boot_rom = !boot_mode_select_pin_i; // see RL5
    end
    // Register writes
    if (mmr_wr_i) begin
      case (mmr_addr_i)
        WAIT_CFG_ADDR: nxt_st.wait_cfg = mmr_wdata_i; // see RL17
        WAIT_CTL_ADDR: nxt_st.wait_mult = mmr_wdata_i[0];
        PROCESSOR_MODE_STATUS_ADDR: begin
          nxt_st.vector_page_pointer = mmr_wdata_i[VECTOR_PAGE_POINTER_LSB +: VECTOR_PAGE_POINTER_W]; // see RL12
          nxt_st.overlay_enable = mmr_wdata_i[OVERLAY_ENABLE_BIT];
        end
        default: ;
      endcase
    end
    case (mmr_addr_i)
      WAIT_CFG_ADDR: nxt_st.mmr_rd = st_ff.wait_cfg;
      WAIT_CTL_ADDR: nxt_st.mmr_rd = {{(DW-1){1'b0}}, st_ff.wait_mult};
      PROCESSOR_MODE_STATUS_ADDR:     nxt_st.mmr_rd = {st_ff.vector_page_pointer, 1'b0, st_ff.overlay_enable, 5'h00};
      default:       nxt_st.mmr_rd = '0;
    endcase
    // Clock gate enable; all fields zero stops the counter
    nxt_st.wclk_en = (nxt_st.wait_cfg[F_W*5-1:0] != '0); // see RL16
    // Vector fetch address: page, slot, four-word spacing
    if (vec_take_i) begin // see RL10
      nxt_st.pc = {st_ff.vector_page_pointer, vec_slot_i, {VEC_WORD_W{1'b0}}}; // see RL11 RL12
      nxt_st.pc_vld = 1'b1;
    end
    // Core access
    if (st_ff.ext_busy) begin
      if (st_ff.wcnt != '0) begin
        if (st_ff.wclk_en) begin
          nxt_st.wcnt = st_ff.wcnt - 4'h1; // see RL23
        end
      end else if (ready_i) begin // see RL15 RL23
        nxt_st.ext_busy = 1'b0;
        nxt_st.ext_oe   = 1'b0;
        nxt_st.done     = 1'b1;
        nxt_st.rdata    = ext_din_i;
      end
    end else if (acc_req_i) begin
      nxt_st.rgn = a_rom ? rom_rgn(acc_addr_i) : RG_NONE;
      if (a_ext) begin
        nxt_st.ext_busy  = 1'b1;
        nxt_st.ext_addr  = acc_addr_i[EXT_AW-1:0]; // see RL8 RL9
        nxt_st.ext_dout  = acc_wdata_i;
        nxt_st.ext_oe    = acc_we_i;
        nxt_st.ext_rw    = !acc_we_i;
        nxt_st.ext_space = acc_space_i;
        nxt_st.wcnt      = st_ff.wclk_en ? scaled_w : '0; // see RL19
      end else begin
        nxt_st.done  = 1'b1;
        nxt_st.rdata = a_mem_rd;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff          <= '0;
      st_ff.wait_cfg <= WAIT_CFG_RST; // see RL19
      st_ff.vector_page_pointer     <= VECTOR_PAGE_POINTER_RST;     // see RL13
      st_ff.boot_rom <= 1'b1;
      st_ff.wclk_en  <= 1'b1;
      st_ff.ext_rw   <= 1'b1;
      st_ff.rgn      <= RG_NONE;
      st_ff.ext_space <= SP_PROG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory writes; no reset so the arrays stay plain storage
  always_ff @(posedge clk_i) begin
    if (acc_req_i && !st_ff.ext_busy && acc_we_i && a_ram) begin // see RL2
      if (acc_addr_i >= RAM_BLK1) begin
        ram1_ff[a_ridx] <= acc_wdata_i;
      end else begin
        ram0_ff[a_ridx] <= acc_wdata_i;
      end
    end
    if (rom_wr_i) begin
      rom_ff[rom_idx_i] <= rom_wdata_i;
    end
  end

  assign mmr_rdata_o   = st_ff.mmr_rd;
  assign acc_rdata_o   = st_ff.rdata;
  assign acc_done_o    = st_ff.done;
  assign acc_busy_o    = st_ff.ext_busy;
  assign acc_rom_rgn_o = st_ff.rgn;
  assign rdb_data_o    = st_ff.rdb;
  assign pc_load_o     = st_ff.pc;
  assign pc_load_vld_o = st_ff.pc_vld;
  assign ext_addr_o    = st_ff.ext_addr;
  assign ext_dout_o    = st_ff.ext_dout;
  assign ext_dout_oe_o = st_ff.ext_oe;
  assign ext_strobe_o  = st_ff.ext_busy;
  assign ext_rw_o      = st_ff.ext_rw;
  assign ext_space_o   = st_ff.ext_space;
  assign wait_clk_en_o = st_ff.wclk_en;
  assign boot_mode_o   = st_ff.boot_rom;
endmodule : emw_top
`default_nettype wire

// ---- emw_checker.sv ----
// Assertion checker for the memory map and wait-state block
`default_nettype none
module emw_checker
  import emw_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // Inputs watched
  input wire logic        mmr_wr_i,
  input wire logic [7:0]  mmr_addr_i,
  input wire logic [15:0] mmr_wdata_i,
  input wire logic        acc_we_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic        vec_take_i,
  input wire logic [4:0]  vec_slot_i,
  input wire logic        ready_i,
  // Outputs watched
  input wire logic [15:0] mmr_rdata_o,
  input wire logic        acc_done_o,
  input wire logic [15:0] pc_load_o,
  input wire logic        pc_load_vld_o,
  input wire logic [5:0]  ext_addr_o,
  input wire logic        ext_dout_oe_o,
  input wire logic        ext_strobe_o,
  input wire logic        ext_rw_o,
  input wire logic        wait_clk_en_o
);
  logic [15:0] cfg_ff;
  logic [3:0]  stab_ff;
  logic [4:0]  run_ff;
  logic        cfg_wr;
  assign cfg_wr = mmr_wr_i && (mmr_addr_i == WAIT_CFG_ADDR);
  // Mirror of the config so gating can be judged once it has settled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff  <= WAIT_CFG_RST;
      stab_ff <= 4'h0;
      run_ff  <= 5'h0;
    end else begin
      if (cfg_wr) cfg_ff <= mmr_wdata_i;
      stab_ff <= cfg_wr ? 4'h0 : ((stab_ff == 4'hf) ? stab_ff : stab_ff + 4'h1);
      run_ff  <= (ext_strobe_o && ready_i) ? run_ff + 5'h1 : 5'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ext_addr_low_a: assert property ($rose(ext_strobe_o) |-> ext_addr_o == 6'($past(acc_addr_i)))
    else $error("external address is not the low six request bits");
  ext_dir_a: assert property ($rose(ext_strobe_o) |-> ext_rw_o == !$past(acc_we_i))
    else $error("external direction differs from request");
  drive_only_write_a: assert property (ext_dout_oe_o |-> ext_strobe_o && !ext_rw_o)
    else $error("data driven outside a write cycle");
  end_gives_done_a: assert property ($fell(ext_strobe_o) |-> acc_done_o)
    else $error("external cycle ended without done");
  ready_low_hold_a: assert property (ext_strobe_o && !ready_i |=> ext_strobe_o)
    else $error("cycle ended while ready low");
  max_waits_a: assert property (run_ff <= 5'd15)
    else $error("more than fourteen programmed waits");
  clock_gate_a: assert property (stab_ff >= 4'h4 |-> wait_clk_en_o == (cfg_ff[14:0] != 15'h0))
    else $error("wait generator enable wrong for config");
  vector_slot_a: assert property (vec_take_i |=> pc_load_vld_o && pc_load_o[6:0] == {$past(vec_slot_i), 2'b00})
    else $error("vector address slot spacing wrong");
  done_pulse_a: assert property (acc_done_o |=> !acc_done_o)
    else $error("done longer than one cycle");
  ctl_reserved_a: assert property ($past(mmr_addr_i) == WAIT_CTL_ADDR |-> mmr_rdata_o[15:1] == 15'h0)
    else $error("wait control reserved bits not zero");
endmodule // emw_checker
bind emw_top emw_checker emw_checker_i (.clk_i, .rstn_i, .mmr_wr_i, .mmr_addr_i, .mmr_wdata_i, .acc_we_i,
  .acc_addr_i, .vec_take_i, .vec_slot_i, .ready_i, .mmr_rdata_o, .acc_done_o, .pc_load_o, .pc_load_vld_o,
  .ext_addr_o, .ext_dout_oe_o, .ext_strobe_o, .ext_rw_o, .wait_clk_en_o);
`default_nettype wire

// ---- emw_ext_model.sv ----
// Behavioural external SRAM, I/O devices and page latch
`default_nettype none
module emw_ext_model
  import emw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [5:0]  ext_addr_o,
  input  wire logic [15:0] ext_dout_o,
  input  wire logic        ext_dout_oe_o,
  input  wire logic        ext_strobe_o,
  input  wire logic        ext_rw_o,
  input  wire emw_space_t  ext_space_o,
  input  wire logic [4:0]  slow_i,
  output var  logic [15:0] ext_din_i,
  output var  logic        ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [128];
  logic        pg = 1'b0;
  logic        tg = 1'b0;
  logic [4:0]  n = 5'h0;
  always @(posedge clk_i) begin
    tg <= ~tg;
    n <= ext_strobe_o ? n + 5'h1 : 5'h0;
    if (ext_strobe_o && ext_dout_oe_o && ext_space_o == SP_IO && ext_addr_o == 6'h3f) pg <= ext_dout_o[0];
    else if (ext_strobe_o && ext_dout_oe_o) mem[{pg, ext_addr_o}] <= ext_dout_o;
  end
  // Idle lines toggle so a stale value never looks valid
  assign ready_i   = ext_strobe_o ? (n >= slow_i) : tg;
  assign ext_din_i = (ext_strobe_o && ext_rw_o) ? mem[{pg, ext_addr_o}] : ({16{tg}} ^ 16'h5a5a);
endmodule // emw_ext_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the memory map and wait-state block
`default_nettype none
module tb_top
  import emw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, boot_mode_select_pin_i = 0, mmr_wr_i = 0, acc_req_i = 0, acc_we_i = 0;
  logic rdb_req_i = 1, vec_take_i = 0, rom_wr_i = 0, acc_done_o, acc_busy_o, pc_load_vld_o, ext_dout_oe_o;
  logic ext_strobe_o, ext_rw_o, ready_i, wait_clk_en_o, boot_mode_o;
  logic [7:0]  mmr_addr_i = 0;
  logic [15:0] mmr_wdata_i = 0, acc_addr_i = 0, acc_wdata_i = 0, rdb_addr_i = 0, rom_wdata_i = 0;
  logic [15:0] mmr_rdata_o, acc_rdata_o, rdb_data_o, pc_load_o, ext_dout_o, ext_din_i;
  logic [11:0] rom_idx_i = 0;
  logic [4:0]  vec_slot_i = 0, slow = 0;
  logic [5:0]  ext_addr_o;
  emw_space_t  acc_space_i = SP_DATA, ext_space_o;
  emw_rom_rgn_t acc_rom_rgn_o;
  int          errors = 0, n_checks = 0, scnt = 0;
  logic [32:0] aq[$];
  logic [15:0] vq[$];
  logic [15:0] ra[7] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfd00, 16'hfe00, 16'hff00, 16'hff80};
  logic [15:0] rg[7] = '{16'h6, 16'h1, 16'h2, 16'h3, 16'h4, 16'h6, 16'h5};
  emw_top emw_top_i (.clk_i, .rstn_i, .boot_mode_select_pin_i, .mmr_wr_i, .mmr_addr_i, .mmr_wdata_i, .mmr_rdata_o,
    .acc_req_i, .acc_we_i, .acc_space_i, .acc_addr_i, .acc_wdata_i, .acc_rdata_o, .acc_done_o, .acc_busy_o,
    .acc_rom_rgn_o, .rdb_req_i, .rdb_addr_i, .rdb_data_o, .vec_take_i, .vec_slot_i, .pc_load_o, .pc_load_vld_o,
    .rom_wr_i, .rom_idx_i, .rom_wdata_i, .ext_addr_o, .ext_dout_o, .ext_dout_oe_o, .ext_din_i, .ext_strobe_o,
    .ext_rw_o, .ext_space_o, .ready_i, .wait_clk_en_o, .boot_mode_o);
  emw_ext_model emw_ext_model_i (.clk_i, .ext_addr_o, .ext_dout_o, .ext_dout_oe_o, .ext_strobe_o, .ext_rw_o,
    .ext_space_o, .slow_i(slow), .ext_din_i, .ready_i);
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rw(input logic [7:0] a, input logic [15:0] d);
    mmr_wr_i = 1;
    mmr_addr_i = a;
    mmr_wdata_i = d;
    @(negedge clk_i);
    mmr_wr_i = 0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [15:0] e);
    mmr_addr_i = a;
    @(negedge clk_i);
    chk(mmr_rdata_o, e);
  endtask
  // Bounded wait until the monitor has consumed every note
  task automatic drain();
    for (int i = 0; i < 200 && (aq.size() + vq.size()) > 0; i++) @(negedge clk_i);
    if ((aq.size() + vq.size()) > 0) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic acc(input logic we, input emw_space_t sp, input logic [15:0] a, d, input int cyc);
    aq.push_back({!we, 16'(cyc), d});
    acc_req_i = 1;
    acc_we_i = we;
    acc_space_i = sp;
    acc_addr_i = a;
    acc_wdata_i = d;
    @(negedge clk_i);
    acc_req_i = 0;
    drain();
  endtask
  task automatic vec(input logic [4:0] s, input logic [15:0] e);
    vq.push_back(e);
    vec_take_i = 1;
    vec_slot_i = s;
    @(negedge clk_i);
    vec_take_i = 0;
    drain();
  endtask
  function automatic int nw(input logic [15:0] c, input logic m, input emw_space_t sp, input logic [15:0] a);
    int l;
    l = (sp == SP_IO) ? 12 : (sp == SP_DATA) ? (a[15] ? 9 : 6) : (a[15] ? 3 : 0);
    return int'((c >> l) & 16'h7) << m;
  endfunction
  // Monitor: sampled at the falling edge, once registered outputs have settled
  always @(negedge clk_i) begin
    if (ext_strobe_o) scnt = scnt + 1;
    if (acc_done_o && aq.size() > 0) begin
      chk(16'(scnt), aq[0][31:16]);
      if (aq[0][32]) chk(acc_rdata_o, aq[0][15:0]);
      void'(aq.pop_front());
      scnt = 0;
    end
    if (pc_load_vld_o && vq.size() > 0) chk(pc_load_o, vq.pop_front());
  end
  initial begin
    logic [15:0] cfg, d, a;
    emw_space_t sp;
    int k, e;
    k = $urandom(24483);
    repeat (5) @(negedge clk_i);
    rstn_i = 1;
    @(negedge clk_i);
    chk(16'(boot_mode_o), 16'h1);
    rr(WAIT_CFG_ADDR, 16'h7fff);
    rr(WAIT_CTL_ADDR, 16'h0);
    rr(PROCESSOR_MODE_STATUS_ADDR, 16'hff80);
    rr(8'h2a, 16'h0);
    vec(5'd0, 16'hff80);
    vec(5'd31, 16'hfffc);
    acc(1, SP_DATA, 16'h8034, 16'h0a5c, 8);
    acc(0, SP_IO, 16'h1234, 16'h0a5c, 8);
    foreach (ra[j]) begin
      rom_wr_i = 1;
      rom_idx_i = ra[j][11:0];
      rom_wdata_i = ~ra[j];
      @(negedge clk_i);
      rom_wr_i = 0;
      acc(0, SP_PROG, ra[j], ~ra[j], 0);
      chk(16'(acc_rom_rgn_o), rg[j]);
    end
    acc(1, SP_DATA, 16'h0080, 16'h2468, 0);
    acc(1, SP_DATA, 16'h2100, 16'h1357, 0);
    acc(1, SP_PROG, 16'h2100, 16'h0, 8);
    rdb_addr_i = 16'h0080;
    acc(0, SP_DATA, 16'h2100, 16'h1357, 0);
    chk(rdb_data_o, 16'h2468);
    rw(PROCESSOR_MODE_STATUS_ADDR, 16'h0820);
    rr(PROCESSOR_MODE_STATUS_ADDR, 16'h0820);
    acc(0, SP_PROG, 16'h2100, 16'h1357, 0);
    vec(5'd3, 16'h080c);
    // Random fields per space, doubled on odd passes, slow device last
    for (k = 0; k < 12; k++) begin
      cfg = 16'($urandom) & 16'h7fff;
      rw(WAIT_CFG_ADDR, cfg);
      rw(WAIT_CTL_ADDR, 16'hfffe | 16'(k % 2));
      rr(WAIT_CTL_ADDR, 16'(k % 2));
      sp = emw_space_t'(k % 3);
      // Low bit cleared so the page latch address is never hit
      a = {k[2], 2'b10, 13'($urandom)} & 16'hfffe;
      d = 16'($urandom);
      slow = (k > 9) ? 5'd15 : 5'd0;
      e = nw(cfg, k[0], sp, a);
      e = ((e > slow) ? e : slow) + 1;
      acc(1, sp, a, d, e);
      acc(0, sp, a ^ 16'h02c0, d, e);
    end
    slow = 0;
    rw(WAIT_CFG_ADDR, 16'h7fff);
    rw(WAIT_CTL_ADDR, 16'h0001);
    acc(1, SP_DATA, 16'h8000, 16'h0, 15);
    rw(WAIT_CFG_ADDR, 16'h0);
    repeat (4) @(negedge clk_i);
    chk(16'(wait_clk_en_o), 16'h0);
    acc(1, SP_IO, 16'h0011, 16'h0, 1);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
